// ### design/snv_defs.vh
// Constants for the serial nonvolatile RAM extended write command logic
// What this block does
// - Double-rate write takes address and data on both clock edges.
// - Any start address; address advances per data byte, wraps top to zero.
// - Write commands store data only while the write-enable latch is 1.
// - Write-enable latch stays set after these write commands complete.
// - Fast write mode byte with upper nibble 1010 enters continuous mode.
// - Mode byte without continuation pattern leaves continuous mode.
// - Double-rate fast write enters continuous mode only on mode byte A5.
// - Double-rate fast write leaves continuous mode on any byte but A5.
// - Two-line data write: serial header, data two bits per clock, MSB line 1.
// - Two-line address/data write: serial opcode, rest two bits per clock.
// - Four-line data write: serial header, data four bits per clock, bit7 line 3.
// - Write-enable latch is bit 1 of the first status register.
// - Only 17 address bits are used; upper address bits are ignored.
`ifndef SNV_DEFS_VH
`define SNV_DEFS_VH

// Opcodes
`define SNV_OP_DDR_WRITE 8'hDE
`define SNV_OP_FAST_WRITE 8'hDA
`define SNV_OP_DDR_FAST_WRITE 8'hDD
`define SNV_OP_TWO_DATA 8'hA2
`define SNV_OP_TWO_ADDR_DATA 8'hA1
`define SNV_OP_FOUR_DATA 8'h32

// Mode byte continuation patterns
`define SNV_MODE_NIBBLE 4'hA
`define SNV_MODE_DDR 8'hA5

// Field positions and lengths
`define SNV_WEL_BIT 1
`define SNV_ADDR_W 17
`define SNV_LEN_OPC 5'h08
`define SNV_LEN_ADDR 5'h18
`define SNV_LEN_MODE 5'h08
`define SNV_LEN_DATA 5'h08

// Reset values
`define SNV_ADDR_RST 17'h00000
`define SNV_CMD_RST 8'h00

`endif

// ### design/snv_sync.v
// Two flip-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module snv_sync #(
   parameter WIDTH = 6,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   // Pins and synchronised copy
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] pin_sync
);
   reg [WIDTH-1:0] stage1;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge sys_clk) begin
            if (!nrst) begin
               stage1[i] <= RST_VAL[i];
               pin_sync[i] <= RST_VAL[i];
            end else begin
               stage1[i] <= pin_in[i];
               pin_sync[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule // snv_sync
`default_nettype wire

// ### design/snv_mem.v
// Byte-wide storage array with one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module snv_mem #(
   parameter ADDR_W = 17
) (
   // Clock
   input wire sys_clk,
   // Write port
   input wire wr_en,
   input wire [ADDR_W-1:0] wr_addr,
   input wire [7:0] wr_data,
   // Read port
   input wire [ADDR_W-1:0] rd_addr,
   output reg [7:0] rd_data
);
   // Nonvolatile contents: no reset on purpose
   reg [7:0] cells [0:(1<<ADDR_W)-1];
   always @(posedge sys_clk) begin
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
      rd_data <= cells[rd_addr];
   end
endmodule // snv_mem
`default_nettype wire

// ### design/snv_write_cmds.v
// Extended write command decoder, pin reconfiguration and array writer
`timescale 1ns/1ps
`default_nettype none
`include "snv_defs.vh"
module snv_write_cmds #(
   parameter ADDR_W = `SNV_ADDR_W
) (
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   // Serial pins; io[2] is the protect pin, io[3] the reset pin
   input wire spi_sck,
   input wire spi_cs_n,
   input wire [3:0] spi_io,
   // First status register from the status logic
   input wire [7:0] first_status_register,
   // Array inspection port
   input wire [ADDR_W-1:0] rd_addr,
   output wire [7:0] rd_data,
   // Status
   output reg continuous_opcode_skip,
   output reg dual_pins_active,
   output reg quad_pins_active,
   output reg cmd_active,
   output reg byte_write_pulse,
   output reg [ADDR_W-1:0] byte_write_addr
);
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_OPC = 3'd1;
   localparam [2:0] ST_ADDR = 3'd2;
   localparam [2:0] ST_MODE = 3'd3;
   localparam [2:0] ST_DATA = 3'd4;
   localparam [2:0] ST_IGNORE = 3'd5;
   localparam [2:0] ST_WAIT_HI = 3'd6;

   // Address, mode and data phases: the body of a command after its opcode
   function in_body;
      input [2:0] st;
      begin
         in_body = (st == ST_ADDR) || (st == ST_MODE) || (st == ST_DATA);
      end
   endfunction

   // Lanes used by a command in a given phase; outside the body every pin
   // keeps its single-line role even though the last command is remembered
   function [2:0] field_lanes;
      input [7:0] cmd;
      input [2:0] st;
      begin
         field_lanes = 3'd1;
         case (cmd)
            `SNV_OP_TWO_DATA: begin
               if (st == ST_DATA) begin
                  field_lanes = 3'd2;
               end
            end
            `SNV_OP_TWO_ADDR_DATA: begin
               if (in_body(st)) begin
                  field_lanes = 3'd2;
               end
            end
            `SNV_OP_FOUR_DATA: begin
               if (st == ST_DATA) begin
                  field_lanes = 3'd4;
               end
            end
            default: field_lanes = 3'd1;
         endcase
      end
   endfunction

   // Double-rate commands clock address, mode and data on both edges
   function is_ddr;
      input [7:0] cmd;
      begin
         is_ddr = (cmd == `SNV_OP_DDR_WRITE) ||
                  (cmd == `SNV_OP_DDR_FAST_WRITE);
      end
   endfunction

   // Only the plain double-rate write goes straight from address to data
   function has_mode;
      input [7:0] cmd;
      begin
         has_mode = (cmd != `SNV_OP_DDR_WRITE);
      end
   endfunction

   function is_known;
      input [7:0] cmd;
      begin
         case (cmd)
            `SNV_OP_DDR_WRITE, `SNV_OP_FAST_WRITE,
            `SNV_OP_DDR_FAST_WRITE, `SNV_OP_TWO_DATA,
            `SNV_OP_TWO_ADDR_DATA, `SNV_OP_FOUR_DATA: is_known = 1'b1;
            default: is_known = 1'b0;
         endcase
      end
   endfunction

   // Synchronised pins: sck, cs_n, io[3:0]
   wire [5:0] pins_s;
   snv_sync #(
      .WIDTH(6),
      .RST_VAL(6'h02)
   ) u_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin_in({spi_io, spi_cs_n, spi_sck}),
      .pin_sync(pins_s)
   );
   wire sck_s = pins_s[0];
   wire cs_n_s = pins_s[1];
   wire [3:0] io_s = pins_s[5:2];

   reg sck_prev;
   reg [2:0] state;
   reg [7:0] cmd;
   reg [7:0] skip_cmd;
   reg [4:0] bit_cnt;
   // Wide enough to hold a whole address field
   reg [23:0] shreg;
   reg [ADDR_W-1:0] addr;
   reg mem_wr_en;
   reg [ADDR_W-1:0] mem_wr_addr;
   reg [7:0] mem_wr_data;

   // Only clock mode 0 is decoded for the double-rate commands: the first
   // falling edge after the opcode already carries address bits.
   // Pins lag two clocks in the synchroniser and one in the edge detector,
   // but each serial clock half period need only span one clock;
   // a faster serial clock loses edges.
   wire sck_rise = sck_s & ~sck_prev;
   wire sck_fall = ~sck_s & sck_prev;
   wire ddr_phase = is_ddr(cmd) && in_body(state);
   wire sample = sck_rise | (sck_fall & ddr_phase);

   wire [2:0] lanes = field_lanes(cmd, state);
   // Counts bits, not clocks: one, two or four per sampled edge
   wire [4:0] cnt_step = bit_cnt + {2'b00, lanes};

   reg [23:0] next_shreg;
   always @* begin
      case (lanes)
         3'd2: next_shreg = {shreg[21:0], io_s[1], io_s[0]};
         3'd4: next_shreg = {shreg[19:0], io_s[3:0]};
         default: next_shreg = {shreg[22:0], io_s[0]};
      endcase
   end

   reg [4:0] field_len;
   always @* begin
      case (state)
         ST_OPC: field_len = `SNV_LEN_OPC;
         ST_ADDR: field_len = `SNV_LEN_ADDR;
         ST_MODE: field_len = `SNV_LEN_MODE;
         default: field_len = `SNV_LEN_DATA;
      endcase
   end
   wire field_done = sample && (cnt_step == field_len);

   wire write_enable_latch = first_status_register[`SNV_WEL_BIT];

   always @(posedge sys_clk) begin
      if (!nrst) begin
         sck_prev <= 1'b0;
         state <= ST_IDLE;
         cmd <= `SNV_CMD_RST;
         skip_cmd <= `SNV_CMD_RST;
         bit_cnt <= 5'h00;
         shreg <= 24'h000000;
         addr <= `SNV_ADDR_RST;
         mem_wr_en <= 1'b0;
         mem_wr_addr <= `SNV_ADDR_RST;
         mem_wr_data <= 8'h00;
         continuous_opcode_skip <= 1'b0;
      end else begin
         sck_prev <= sck_s;
         mem_wr_en <= 1'b0;
         if (cs_n_s) begin
            // Partial fields are simply dropped; skip flag is kept
            state <= ST_IDLE;
            bit_cnt <= 5'h00;
         end else begin
            case (state)
               ST_IDLE: begin
                  // One cycle here reloads the remembered command before any edge
                  bit_cnt <= 5'h00;
                  if (continuous_opcode_skip) begin
                     cmd <= skip_cmd;
                     state <= ST_ADDR;
                  end else begin
                     state <= ST_OPC;
                  end
               end
               ST_OPC: begin
                  if (sample) begin
                     shreg <= next_shreg;
                     bit_cnt <= cnt_step;
                  end
                  if (field_done) begin
                     bit_cnt <= 5'h00;
                     cmd <= next_shreg[7:0];
                     if (is_known(next_shreg[7:0])) begin
                        state <= ST_ADDR;
                     end else begin
                        state <= ST_IGNORE;
                     end
                  end
               end
               ST_ADDR: begin
                  if (sample) begin
                     shreg <= next_shreg;
                     bit_cnt <= cnt_step;
                  end
                  if (field_done) begin
                     bit_cnt <= 5'h00;
                     // Bits above the top address bit are dropped
                     addr <= next_shreg[ADDR_W-1:0];
                     if (has_mode(cmd)) begin
                        state <= ST_MODE;
                     end else begin
                        state <= ST_DATA;
                     end
                  end
               end
               ST_MODE: begin
                  if (sample) begin
                     shreg <= next_shreg;
                     bit_cnt <= cnt_step;
                  end
                  if (field_done) begin
                     bit_cnt <= 5'h00;
                     state <= ST_DATA;
                     // The command whose mode byte sets the flag is replayed
                     skip_cmd <= cmd;
                     if (cmd == `SNV_OP_DDR_FAST_WRITE) begin
                        continuous_opcode_skip <=
                           (next_shreg[7:0] == `SNV_MODE_DDR);
                     end else begin
                        continuous_opcode_skip <=
                           (next_shreg[7:4] == `SNV_MODE_NIBBLE);
                     end
                  end
               end
               ST_DATA: begin
                  if (sample) begin
                     shreg <= next_shreg;
                     bit_cnt <= cnt_step;
                  end
                  if (field_done) begin
                     bit_cnt <= 5'h00;
                     // Latch is read per byte and never cleared here; with it
                     // low the address still advances, so bursts stay aligned
                     mem_wr_en <= write_enable_latch;
                     mem_wr_addr <= addr;
                     mem_wr_data <= next_shreg[7:0];
                     // Natural overflow of the 17-bit counter is the wrap
                     addr <= addr + 1'b1;
                  end
               end
               ST_IGNORE: begin
                  // Unknown opcode: deaf until select rises, flag untouched
                  state <= ST_WAIT_HI;
               end
               ST_WAIT_HI: begin
                  state <= ST_WAIT_HI;
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Pin roles follow the phase being shifted; with select high every pin
   // falls back to its single-line role
   always @(posedge sys_clk) begin
      if (!nrst) begin
         dual_pins_active <= 1'b0;
         quad_pins_active <= 1'b0;
         cmd_active <= 1'b0;
         byte_write_pulse <= 1'b0;
         byte_write_addr <= `SNV_ADDR_RST;
      end else begin
         cmd_active <= ~cs_n_s && in_body(state);
         dual_pins_active <= ~cs_n_s && (lanes == 3'd2);
         quad_pins_active <= ~cs_n_s && (lanes == 3'd4);
         byte_write_pulse <= mem_wr_en;
         byte_write_addr <= mem_wr_addr;
      end
   end

   snv_mem #(
      .ADDR_W(ADDR_W)
   ) u_mem (
      .sys_clk(sys_clk),
      .wr_en(mem_wr_en),
      .wr_addr(mem_wr_addr),
      .wr_data(mem_wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );
endmodule // snv_write_cmds
`default_nettype wire

// ### tb/snv_host_model.sv
// Host controller model that drives the serial pins of the write logic
`timescale 1ns/1ps
`default_nettype none
`include "snv_defs.vh"
module snv_host_model (
   // Clock
   input wire logic sys_clk,
   // Serial pins
   output logic spi_sck,
   output logic spi_cs_n,
   output logic [3:0] spi_io
);
   initial begin
      spi_sck = 1'b0; // Mode 0 only, clock idles low
      spi_cs_n = 1'b1;
      spi_io = 4'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Six clocks a half period so every edge survives the synchroniser
   task automatic shift(input logic [31:0] v, input int n, input int w,
                        input bit ddr);
      int i;
      for (i = n; i > 0; i = i - w) begin
         tick(3);
         spi_io = ~spi_io; // Unused lanes toggle so stale levels never match
         case (w)
            1: spi_io[0] = v[i-1];
            2: spi_io[1:0] = {v[i-1], v[i-2]};
            default: spi_io = {v[i-1], v[i-2], v[i-3], v[i-4]};
         endcase
         tick(3);
         spi_sck = ddr ? ~spi_sck : 1'b1;
         if (!ddr) begin
            tick(6);
            spi_sck = 1'b0;
         end
      end
   endtask
   task automatic xfer(input logic [7:0] op, input bit skip,
                       input logic [23:0] adr, input logic [7:0] mode,
                       input int nb, input logic [7:0] d0, input int tail);
      int k;
      int aw;
      int dw;
      bit ddr;
      ddr = (op == `SNV_OP_DDR_WRITE) || (op == `SNV_OP_DDR_FAST_WRITE);
      aw = (op == `SNV_OP_TWO_ADDR_DATA) ? 2 : 1;
      dw = (op == `SNV_OP_FOUR_DATA) ? 4 :
           ((op == `SNV_OP_TWO_ADDR_DATA || op == `SNV_OP_TWO_DATA) ? 2 : 1);
      spi_cs_n = 1'b0;
      if (!skip && !ddr) shift({24'h000000, op}, 8, 1, 1'b0);
      if (!skip && ddr) begin
         // Last opcode bit ends on a rise; the fall after it carries A23
         shift({24'h000000, op} >> 1, 7, 1, 1'b0);
         shift({24'h000000, op}, 1, 1, 1'b1);
      end
      shift({8'h00, adr}, 24, aw, ddr);
      if (op != `SNV_OP_DDR_WRITE) shift({24'h000000, mode}, 8, aw, ddr);
      for (k = 0; k < nb; k++) shift({24'h000000, d0 + k[7:0]}, 8, dw, ddr);
      if (tail > 0) shift(32'hFFFFFFFF, tail, dw, ddr);
      tick(6);
      spi_cs_n = 1'b1;
      tick(8);
      spi_sck = 1'b0; // Double-rate frames sent with an opcode end high; idle low again
      tick(4);
   endtask
endmodule // snv_host_model
`default_nettype wire

// ### tb/snv_write_cmds_monitor.sv
// Port-level assertions for the extended write command logic
`timescale 1ns/1ps
`default_nettype none
module snv_write_cmds_monitor #(
   parameter ADDR_W = 17
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic spi_cs_n,
   input wire logic [7:0] first_status_register,
   input wire logic continuous_opcode_skip,
   input wire logic dual_pins_active,
   input wire logic quad_pins_active,
   input wire logic cmd_active,
   input wire logic byte_write_pulse,
   input wire logic [ADDR_W-1:0] byte_write_addr
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic [ADDR_W-1:0] last_addr;
   logic have_prev;
   // Chain of addresses is only meaningful within one frame
   always @(posedge sys_clk) begin
      if (!nrst) begin
         have_prev <= 1'b0;
         last_addr <= {ADDR_W{1'b0}};
      end else if (byte_write_pulse) begin
         have_prev <= 1'b1;
         last_addr <= byte_write_addr;
      end else if (!cmd_active) begin
         have_prev <= 1'b0;
      end
   end
   property p_pulse_cause;
      byte_write_pulse |-> $past(cmd_active, 2);
   endproperty
   a_pulse_cause: assert property (p_pulse_cause) else $error("write outside command");
   property p_pulse_single;
      byte_write_pulse |=> !byte_write_pulse;
   endproperty
   a_pulse_single: assert property (p_pulse_single) else $error("pulse too long");
   property p_pulse_wel;
      byte_write_pulse |-> $past(first_status_register[1], 2);
   endproperty
   a_pulse_wel: assert property (p_pulse_wel) else $error("write without latch");
   property p_addr_step;
      byte_write_pulse && have_prev |->
         byte_write_addr == ADDR_W'(last_addr + 1'b1);
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address step wrong");
   property p_lanes_excl;
      !(dual_pins_active && quad_pins_active);
   endproperty
   a_lanes_excl: assert property (p_lanes_excl) else $error("two lane modes");
   property p_dual_in_cmd;
      dual_pins_active |-> cmd_active;
   endproperty
   a_dual_in_cmd: assert property (p_dual_in_cmd) else $error("dual lanes idle");
   property p_quad_in_cmd;
      quad_pins_active |-> cmd_active;
   endproperty
   a_quad_in_cmd: assert property (p_quad_in_cmd) else $error("quad lanes idle");
   property p_idle_release;
      spi_cs_n [*6] |->
         !cmd_active && !dual_pins_active && !quad_pins_active;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("pins not released");
   property p_flag_change;
      $changed(continuous_opcode_skip) |-> $past(cmd_active);
   endproperty
   a_flag_change: assert property (p_flag_change) else $error("flag changed idle");
endmodule // snv_write_cmds_monitor
bind snv_write_cmds snv_write_cmds_monitor #(.ADDR_W(ADDR_W)) u_mon (
   .sys_clk(sys_clk), .nrst(nrst), .spi_cs_n(spi_cs_n),
   .first_status_register(first_status_register),
   .continuous_opcode_skip(continuous_opcode_skip),
   .dual_pins_active(dual_pins_active), .quad_pins_active(quad_pins_active),
   .cmd_active(cmd_active), .byte_write_pulse(byte_write_pulse),
   .byte_write_addr(byte_write_addr));
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the extended write command logic
`timescale 1ns/1ps
`default_nettype none
`include "snv_defs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] first_status_register = 8'h02;
   logic [16:0] rd_addr = 17'h00000;
   wire spi_sck, spi_cs_n, skip, dual, quad, act, pulse;
   wire [3:0] spi_io;
   wire [7:0] rd_data;
   wire [16:0] waddr;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   logic dual_seen = 1'b0;
   logic quad_seen = 1'b0;
   logic act_seen = 1'b0;
   logic [16:0] seen[$];
   always #5 sys_clk = ~sys_clk;
   snv_host_model host (.sys_clk(sys_clk), .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n), .spi_io(spi_io));
   snv_write_cmds uut (.sys_clk(sys_clk), .nrst(nrst), .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n), .spi_io(spi_io),
      .first_status_register(first_status_register), .rd_addr(rd_addr),
      .rd_data(rd_data), .continuous_opcode_skip(skip),
      .dual_pins_active(dual), .quad_pins_active(quad), .cmd_active(act),
      .byte_write_pulse(pulse), .byte_write_addr(waddr));
   task automatic wrap_up;
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (pulse === 1'b1) seen.push_back(waddr);
      if (dual === 1'b1) dual_seen = 1'b1;
      if (quad === 1'b1) quad_seen = 1'b1;
      if (act === 1'b1) act_seen = 1'b1;
      if (cycles == 40000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic check_bytes(input logic [16:0] a0, input int nb,
                              input logic [7:0] d0);
      int k;
      `CHK("write count", nb, seen.size())
      for (k = 0; k < nb && k < seen.size(); k++) begin
         `CHK("write addr", a0 + k[16:0], seen[k])
         rd_addr = a0 + k[16:0];
         host.tick(2);
         `CHK("cell", d0 + k[7:0], rd_data)
      end
      seen.delete();
   endtask
   task automatic t_gate;
      first_status_register = 8'hFD;
      host.xfer(`SNV_OP_FAST_WRITE, 0, 24'h000010, 8'h00, 2, 8'h11, 0);
      check_bytes(17'h00010, 0, 8'h00);
      `CHK("active", 1'b1, act_seen)
      first_status_register = 8'h02;
      act_seen = 1'b0;
      // Unknown opcode with a continuation pattern: nothing may happen
      host.xfer(8'h5C, 0, 24'h000020, 8'hA0, 2, 8'h22, 0);
      check_bytes(17'h00020, 0, 8'h00);
      `CHK("active", 1'b0, act_seen)
      `CHK("flag", 1'b0, skip)
   endtask
   task automatic t_lanes;
      logic [7:0] ops [6] = '{`SNV_OP_DDR_WRITE, `SNV_OP_FAST_WRITE,
         `SNV_OP_DDR_FAST_WRITE, `SNV_OP_TWO_DATA, `SNV_OP_TWO_ADDR_DATA,
         `SNV_OP_FOUR_DATA};
      int i;
      logic two;
      logic four;
      for (i = 0; i < 6; i++) begin
         two = ops[i] == `SNV_OP_TWO_DATA || ops[i] == `SNV_OP_TWO_ADDR_DATA;
         four = ops[i] == `SNV_OP_FOUR_DATA;
         host.xfer(ops[i], 0, {8'hFF, 16'h0100 + 16'(i * 16)}, 8'h00, 2,
                   8'h30 + 8'(i * 8), 0);
         check_bytes({1'b1, 16'h0100 + 16'(i * 16)}, 2, 8'h30 + 8'(i * 8));
         `CHK("flag", 1'b0, skip)
         `CHK("dual seen", two, dual_seen)
         `CHK("quad seen", four, quad_seen)
         dual_seen = 1'b0;
         quad_seen = 1'b0;
      end
   endtask
   task automatic t_wrap;
      host.xfer(`SNV_OP_DDR_WRITE, 0, 24'h01FFFF, 8'h00, 2, 8'hC3, 0);
      check_bytes(17'h1FFFF, 2, 8'hC3);
   endtask
   task automatic t_cont;
      host.xfer(`SNV_OP_FAST_WRITE, 0, 24'h000200, 8'hA3, 1, 8'h5A, 0);
      `CHK("flag", 1'b1, skip)
      seen.delete();
      host.xfer(`SNV_OP_FAST_WRITE, 1, 24'h000300, 8'h00, 1, 8'h6B, 0);
      check_bytes(17'h00300, 1, 8'h6B);
      `CHK("flag", 1'b0, skip)
      host.xfer(`SNV_OP_DDR_FAST_WRITE, 0, 24'h000310, 8'hAF, 1, 8'h01, 0);
      `CHK("flag", 1'b0, skip)
      host.xfer(`SNV_OP_DDR_FAST_WRITE, 0, 24'h000320, 8'hA5, 1, 8'h02, 0);
      `CHK("flag", 1'b1, skip)
      seen.delete();
      host.xfer(`SNV_OP_DDR_FAST_WRITE, 1, 24'h000330, 8'hA4, 1, 8'h7E, 0);
      check_bytes(17'h00330, 1, 8'h7E);
      `CHK("flag", 1'b0, skip)
   endtask
   task automatic t_partial;
      host.xfer(`SNV_OP_TWO_DATA, 0, 24'h000400, 8'h00, 1, 8'h9C, 4);
      check_bytes(17'h00400, 1, 8'h9C);
      `CHK("dual lanes", 1'b0, dual)
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      host.tick(4);
      t_gate();
      t_lanes();
      t_wrap();
      t_cont();
      t_partial();
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
